// ### src/adjust_timer.sv
// Purpose: down-counter timing one calibration transfer
// Assumes: start_in is a one-cycle pulse
// Notes:   a start in the cycle of done reloads the counter
`timescale 1ns/1ps
`default_nettype none
module adjust_timer #(
  parameter int CYCLES = 4
) (
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  input  wire logic start_in,
  output logic      done_out
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
    end else if (start_in) begin
      cnt_q <= CNT_LOAD;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_ONE;
    end
  end

  assign done_out = (cnt_q == CNT_ONE);

endmodule : adjust_timer
`default_nettype wire

// ### src/calib_bank_pkg.sv
// Purpose: shared constants for the banked per-channel calibration registers
// Assumes: 7-bit register address, 16-bit register data
// Notes:   all offsets, field positions, reset values and counts live here
package calib_bank_pkg;

  localparam int          NUM_CH       = 4;
  localparam int          ADDR_W       = 7;
  localparam int          DATA_W       = 16;
  localparam int          VAL_W        = 10;
  localparam int          TRIM_W       = 4;
  localparam int          SEL_W        = 3;
  localparam int          CMD_W        = 2;

  // register offsets
  localparam logic [6:0]  ADDR_BANK_SELECT = 7'h0F;
  localparam logic [6:0]  ADDR_CAL_CMD     = 7'h10;
  localparam logic [6:0]  ADDR_CAL_BUSY    = 7'h11;
  localparam logic [6:0]  ADDR_CH_STATE    = 7'h12;
  localparam logic [6:0]  ADDR_TRIM        = 7'h13;
  localparam logic [6:0]  ADDR_CUR_OFFSET  = 7'h21;
  localparam logic [6:0]  ADDR_CUR_GAIN    = 7'h23;

  // channel-select codes
  localparam logic [2:0]  SEL_NONE     = 3'h0;
  localparam logic [2:0]  SEL_CH_A     = 3'h1;
  localparam logic [2:0]  SEL_CH_D     = 3'h4;

  // calibration command field positions (low bit of each pair)
  localparam int          OFFSET_CMD_LSB = 6;
  localparam int          GAIN_CMD_LSB   = 4;
  localparam int          PHASE_CMD_LSB  = 2;
  localparam int          CMD_FIELD_LSB  = 2;
  localparam int          CMD_FIELD_W    = 6;
  localparam logic [1:0]  CMD_IDLE       = 2'h0;
  localparam logic [1:0]  CMD_TRANSFER   = 2'h2;

  // field positions of the status registers
  localparam int          BUSY_BIT     = 0;
  localparam int          ACTIVE_BIT   = 0;

  // reset values
  localparam logic [5:0]  CMD_RESET    = 6'h00;
  localparam logic [3:0]  TRIM_RESET   = 4'h7;
  localparam logic [9:0]  VALUE_RESET  = 10'h200;

  // duration of one adjustment, in clock cycles
  localparam int          ADJUST_CYCLES = 4;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_GAIN,
    SEQ_OFFSET,
    SEQ_PHASE
  } seq_state_type;

endpackage : calib_bank_pkg

// ### src/channel_banked_calib_regs.sv
// Purpose: banked per-channel calibration, status and trim registers
// Assumes: register strobes come from the serial framing logic, same clock
// Notes:   one bank per converter channel, chosen by the bank select register
`timescale 1ns/1ps
`default_nettype none
module channel_banked_calib_regs
  import calib_bank_pkg::*;
#(
  parameter int ADJ_CYCLES = calib_bank_pkg::ADJUST_CYCLES
) (
  input  wire logic                                     clk_sys_in,
  input  wire logic                                     rstn_in,
  input  wire logic                                     reg_wr_in,
  input  wire logic                                     reg_rd_in,
  input  wire logic [calib_bank_pkg::ADDR_W-1:0]        reg_addr_in,
  input  wire logic [calib_bank_pkg::DATA_W-1:0]        reg_wdata_in,
  output logic      [calib_bank_pkg::DATA_W-1:0]        reg_rdata_out,
  output logic                                          reg_rvalid_out,
  input  wire logic [calib_bank_pkg::NUM_CH-1:0]        channel_active_in,
  input  wire logic [calib_bank_pkg::NUM_CH-1:0]
                    [calib_bank_pkg::VAL_W-1:0]         ext_offset_in,
  input  wire logic [calib_bank_pkg::NUM_CH-1:0]
                    [calib_bank_pkg::VAL_W-1:0]         ext_gain_in,
  input  wire logic [calib_bank_pkg::NUM_CH-1:0]
                    [calib_bank_pkg::VAL_W-1:0]         ext_phase_in,
  output logic      [calib_bank_pkg::NUM_CH-1:0]
                    [calib_bank_pkg::VAL_W-1:0]         cur_offset_out,
  output logic      [calib_bank_pkg::NUM_CH-1:0]
                    [calib_bank_pkg::VAL_W-1:0]         cur_gain_out,
  output logic      [calib_bank_pkg::NUM_CH-1:0]
                    [calib_bank_pkg::VAL_W-1:0]         cur_phase_out,
  output logic      [calib_bank_pkg::NUM_CH-1:0]
                    [calib_bank_pkg::TRIM_W-1:0]        termination_trim_code_out,
  output logic      [calib_bank_pkg::NUM_CH-1:0]        cal_busy_out,
  output logic      [calib_bank_pkg::SEL_W-1:0]         bank_select_out
);

  import calib_bank_pkg::*;

  logic [SEL_W-1:0]                bank_select_q;
  logic                            sel_valid;
  logic [1:0]                      sel_idx;
  logic [NUM_CH-1:0]               bank_hit;
  logic [NUM_CH-1:0]               channel_active_flag;
  logic [NUM_CH-1:0][CMD_FIELD_W-1:0] cmd_q;
  logic [NUM_CH-1:0][TRIM_W-1:0]   trim_q;
  logic [NUM_CH-1:0][VAL_W-1:0]    cur_offset_q;
  logic [NUM_CH-1:0][VAL_W-1:0]    cur_gain_q;
  logic [NUM_CH-1:0][VAL_W-1:0]    cur_phase_q;
  logic [NUM_CH-1:0]               busy_q;
  logic [DATA_W-1:0]               rdata_q;
  logic                            rvalid_q;
  logic [DATA_W-1:0]               rdata_d;

  // decode of the bank select code into a channel index
  always_comb begin
    sel_valid = (bank_select_q >= SEL_CH_A) && (bank_select_q <= SEL_CH_D);
    sel_idx   = 2'(bank_select_q - SEL_CH_A);
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      bank_select_q <= SEL_NONE;
    end else if (reg_wr_in && reg_addr_in == ADDR_BANK_SELECT) begin
      bank_select_q <= reg_wdata_in[SEL_W-1:0];
    end
  end

  // standby levels come from the analog side, so they are synchronised
  level_sync #(
    .WIDTH     (NUM_CH)
  ) u_active_sync (
    .clk_sys_in(clk_sys_in),
    .rstn_in   (rstn_in),
    .async_in  (channel_active_in),
    .level_out (channel_active_flag)
  );

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_bank
      seq_state_type       state_q;
      seq_state_type       state_d;
      logic [2:0]          pend_q;
      logic [2:0]          pend_d;
      logic [2:0]          launch;
      logic                cmd_wr;
      logic                trim_wr;
      logic                start;
      logic                done;
      logic [CMD_FIELD_W-1:0] new_cmd;

      assign bank_hit[ch] = sel_valid && (sel_idx == 2'(ch));
      assign cmd_wr  = reg_wr_in && bank_hit[ch]
                       && reg_addr_in == ADDR_CAL_CMD;
      assign trim_wr = reg_wr_in && bank_hit[ch]
                       && reg_addr_in == ADDR_TRIM;
      assign new_cmd = reg_wdata_in[CMD_FIELD_LSB +: CMD_FIELD_W];

      // launch mask: {phase, offset, gain}; only code 10 launches
      always_comb begin
        launch[0] = reg_wdata_in[GAIN_CMD_LSB +: CMD_W] == CMD_TRANSFER;
        launch[1] = reg_wdata_in[OFFSET_CMD_LSB +: CMD_W]
                    == CMD_TRANSFER;
        launch[2] = reg_wdata_in[PHASE_CMD_LSB +: CMD_W]
                    == CMD_TRANSFER;
      end

      // fields hold their value after the transfer completes
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          cmd_q[ch] <= CMD_RESET;
        end else if (cmd_wr) begin
          cmd_q[ch] <= new_cmd;
        end
      end

      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          trim_q[ch] <= TRIM_RESET;
        end else if (trim_wr) begin
          trim_q[ch] <= reg_wdata_in[TRIM_W-1:0];
        end
      end

      // sequencer: one transfer at a time, gain before offset before phase
      always_comb begin
        pend_d  = pend_q;
        state_d = state_q;
        start   = 1'b0;
        if (state_q == SEQ_IDLE) begin
          if (cmd_wr && launch != 3'b000) begin
            pend_d = launch;
          end
        end else if (done) begin
          unique case (state_q)
            SEQ_GAIN:   pend_d[0] = 1'b0;
            SEQ_OFFSET: pend_d[1] = 1'b0;
            SEQ_PHASE:  pend_d[2] = 1'b0;
            default:    pend_d    = pend_q;
          endcase
        end
        if (state_q == SEQ_IDLE || done) begin
          if (pend_d[0]) begin
            state_d = SEQ_GAIN;
          end else if (pend_d[1]) begin
            state_d = SEQ_OFFSET;
          end else if (pend_d[2]) begin
            state_d = SEQ_PHASE;
          end else begin
            state_d = SEQ_IDLE;
          end
          start = (state_d != SEQ_IDLE);
        end
      end

      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          state_q <= SEQ_IDLE;
          pend_q  <= 3'b000;
        end else begin
          state_q <= state_d;
          pend_q  <= pend_d;
        end
      end

      adjust_timer #(
        .CYCLES    (ADJ_CYCLES)
      ) u_timer (
        .clk_sys_in(clk_sys_in),
        .rstn_in   (rstn_in),
        .start_in  (start),
        .done_out  (done)
      );

      // live settings move only when their transfer finishes
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          cur_gain_q[ch]   <= VALUE_RESET;
          cur_offset_q[ch] <= VALUE_RESET;
          cur_phase_q[ch]  <= VALUE_RESET;
        end else if (done) begin
          if (state_q == SEQ_GAIN) begin
            cur_gain_q[ch] <= ext_gain_in[ch];
          end
          if (state_q == SEQ_OFFSET) begin
            cur_offset_q[ch] <= ext_offset_in[ch];
          end
          if (state_q == SEQ_PHASE) begin
            cur_phase_q[ch] <= ext_phase_in[ch];
          end
        end
      end

      // busy tracks the sequencer from launch to the last transfer
      always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
          busy_q[ch] <= 1'b0;
        end else begin
          busy_q[ch] <= (state_d != SEQ_IDLE);
        end
      end
    end
  endgenerate

  // read data of the selected bank; no bank or unknown address reads zero
  always_comb begin
    rdata_d = '0;
    if (reg_addr_in == ADDR_BANK_SELECT) begin
      rdata_d[SEL_W-1:0] = bank_select_q;
    end else if (sel_valid) begin
      unique case (reg_addr_in)
        ADDR_CAL_CMD:
          rdata_d[CMD_FIELD_LSB +: CMD_FIELD_W] = cmd_q[sel_idx];
        ADDR_CAL_BUSY:
          rdata_d[BUSY_BIT] = busy_q[sel_idx];
        ADDR_CH_STATE:
          rdata_d[ACTIVE_BIT] = channel_active_flag[sel_idx];
        ADDR_TRIM:
          rdata_d[TRIM_W-1:0] = trim_q[sel_idx];
        ADDR_CUR_OFFSET:
          rdata_d[VAL_W-1:0] = cur_offset_q[sel_idx];
        ADDR_CUR_GAIN:
          rdata_d[VAL_W-1:0] = cur_gain_q[sel_idx];
        default:
          rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata_out             = rdata_q;
  assign reg_rvalid_out            = rvalid_q;
  assign cur_offset_out            = cur_offset_q;
  assign cur_gain_out              = cur_gain_q;
  assign cur_phase_out             = cur_phase_q;
  assign termination_trim_code_out = trim_q;
  assign cal_busy_out              = busy_q;
  assign bank_select_out           = bank_select_q;

endmodule : channel_banked_calib_regs
`default_nettype wire

// ### src/level_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin levels
// Assumes: inputs are asynchronous to clk_sys_in
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] level_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // per bit: take the new level only when the last two stages agree
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      level_q <= '0;
    end else begin
      level_q <= (stage2_q & stage3_q) | (level_q & (stage2_q | stage3_q));
    end
  end

  assign level_out = level_q;

endmodule : level_sync
`default_nettype wire

// ### test/calib_chk.sv
// Purpose: port-level checker for the banked calibration registers
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to the design top; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module calib_chk
  import calib_bank_pkg::*;
(
  input wire logic                           clk_sys_in,
  input wire logic                           rstn_in,
  input wire logic                           reg_wr_in,
  input wire logic                           reg_rd_in,
  input wire logic [ADDR_W-1:0]              reg_addr_in,
  input wire logic [DATA_W-1:0]              reg_wdata_in,
  input wire logic                           reg_rvalid_out,
  input wire logic [NUM_CH-1:0][VAL_W-1:0]   cur_offset_out,
  input wire logic [NUM_CH-1:0][VAL_W-1:0]   cur_gain_out,
  input wire logic [NUM_CH-1:0][VAL_W-1:0]   cur_phase_out,
  input wire logic [NUM_CH-1:0][TRIM_W-1:0]  termination_trim_code_out,
  input wire logic [NUM_CH-1:0]              cal_busy_out,
  input wire logic [SEL_W-1:0]               bank_select_out
);
  import calib_bank_pkg::*;
  logic [1:0] ch;
  logic       bank_ok;
  assign ch      = bank_select_out[1:0] - 2'h1;
  assign bank_ok = bank_select_out inside {[SEL_CH_A:SEL_CH_D]};
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  bank_write_a: assert property (reg_wr_in && reg_addr_in == ADDR_BANK_SELECT
    |=> bank_select_out == $past(reg_wdata_in[2:0]))
    else $error("bank select not taken");
  no_bank_a: assert property (reg_wr_in && reg_addr_in == ADDR_TRIM && !bank_ok
    |=> $stable(termination_trim_code_out))
    else $error("trim written with no bank");
  launch_busy_a: assert property (reg_wr_in && reg_addr_in == ADDR_CAL_CMD
    && bank_ok && reg_wdata_in[5:4] == CMD_TRANSFER && !cal_busy_out[ch]
    |=> cal_busy_out[$past(ch)])
    else $error("busy not raised by command");
  offset_guard_a: assert property ($changed(cur_offset_out)
    |-> $past(|cal_busy_out))
    else $error("offset changed outside adjustment");
  gain_guard_a: assert property ($changed(cur_gain_out) |-> $past(|cal_busy_out))
    else $error("gain changed outside adjustment");
  phase_guard_a: assert property ($changed(cur_phase_out) |-> $past(|cal_busy_out))
    else $error("phase changed outside adjustment");
  one_at_time_a: assert property (!($changed(cur_gain_out)
    && ($changed(cur_offset_out) || $changed(cur_phase_out))))
    else $error("adjustments overlapped");
  busy_ro_a: assert property (reg_wr_in && reg_addr_in == ADDR_CAL_BUSY
    && cal_busy_out == '0 |=> cal_busy_out == '0)
    else $error("busy register took a write");
  trim_reset_a: assert property ($rose(rstn_in)
    |-> termination_trim_code_out == {NUM_CH{TRIM_RESET}} && cal_busy_out == '0)
    else $error("bad reset values");
  read_valid_a: assert property (reg_rd_in |=> reg_rvalid_out ##1 !$past(reg_rd_in)
    || reg_rvalid_out)
    else $error("read answer missing");
endmodule : calib_chk

bind channel_banked_calib_regs calib_chk u_chk (.clk_sys_in, .rstn_in,
  .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rvalid_out,
  .cur_offset_out, .cur_gain_out, .cur_phase_out,
  .termination_trim_code_out, .cal_busy_out, .bank_select_out);
`default_nettype wire

// ### test/reg_host.sv
// Purpose: serial host model issuing register writes and reads
// Assumes: strobes are one-cycle pulses launched after a rising edge
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module reg_host (
  input  wire logic        clk_sys_in,
  input  wire logic [15:0] reg_rdata_in,
  input  wire logic        reg_rvalid_in,
  output var  logic        reg_wr_out,
  output var  logic        reg_rd_out,
  output var  logic [6:0]  reg_addr_out,
  output var  logic [15:0] reg_wdata_out
);
  initial begin
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_addr_out  = 7'h00;
    reg_wdata_out = 16'h0000;
  end
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_wr_out    <= 1'b1;
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    @(posedge clk_sys_in);
    reg_wr_out    <= 1'b0;
    reg_addr_out  <= ~a;
    reg_wdata_out <= ~d;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk_sys_in);
    reg_rd_out   <= 1'b1;
    reg_addr_out <= a;
    @(posedge clk_sys_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~a;
    // answer stands in the cycle after the strobe edge; a missing one reads x
    @(posedge clk_sys_in);
    d = reg_rvalid_in ? reg_rdata_in : 'x;
  endtask : rd
  // bank chosen before any per-channel access
  task automatic sel(input logic [2:0] c);
    wr(7'h0F, {13'h0000, c});
  endtask : sel
endmodule : reg_host
`default_nettype wire

// ### test/tb_top.sv
// Purpose: self-checking bench for the banked calibration registers
// Assumes: adjustments shortened to two cycles
// Notes:   register traffic goes through the host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import calib_bank_pkg::*;
  logic clk_sys_in;
  logic rstn_in;
  logic reg_wr, reg_rd, rvalid;
  logic [6:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [3:0] act;
  logic [3:0][9:0] eo, eg, ep, co, cg, cp;
  logic [3:0][3:0] trim;
  logic [3:0] busy;
  logic [2:0] bank;
  int n_fail = 0, checks = 0, cyc = 0;
  logic [15:0] v3[3] = '{16'h0054, 16'h00FC, 16'h0000};

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  reg_host host (.clk_sys_in, .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd), .reg_addr_out(addr), .reg_wdata_out(wdata));
  channel_banked_calib_regs #(.ADJ_CYCLES(2)) DUT (.clk_sys_in, .rstn_in,
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .channel_active_in(act), .ext_offset_in(eo), .ext_gain_in(eg),
    .ext_phase_in(ep), .cur_offset_out(co), .cur_gain_out(cg),
    .cur_phase_out(cp), .termination_trim_code_out(trim),
    .cal_busy_out(busy), .bank_select_out(bank));

  task automatic chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic t_reset;
    chk(cg[1], 16'h0200, "gain reset");
    chk(bank, 16'h0000, "bank reset");
    for (int c = 1; c <= 4; c++) begin
      host.sel(c[2:0]);
      host.rd(ADDR_TRIM, d);
      chk(d, 16'h0007, "trim reset");
    end
    host.sel(3'h0);
    host.rd(ADDR_TRIM, d);
    chk(d, 16'h0000, "no bank read");
    host.sel(3'h5);
    host.wr(ADDR_TRIM, 16'h0001);
    #1 chk(trim, 16'h7777, "no bank write");
    $display("reset test done");
  endtask : t_reset

  task automatic t_trim;
    logic [3:0] v[4] = '{4'h0, 4'h2, 4'h3, 4'hF};
    for (int c = 0; c < 4; c++) begin
      host.sel(c[2:0] + 3'h1);
      host.wr(ADDR_TRIM, {12'h000, v[c]});
    end
    #1 chk(trim, 16'hF320, "banked trim");
    host.rd(ADDR_TRIM, d);
    chk(d, 16'h000F, "trim readback");
    $display("trim test done");
  endtask : t_trim

  task automatic t_cal;
    int tg, to;
    logic bg;
    tg = 0;
    to = 0;
    bg = 1'b0;
    @(posedge clk_sys_in);
    eg[1] <= 10'h155;
    eg[0] <= 10'h0F0;
    eo[1] <= 10'h0AA;
    ep[1] <= 10'h3FF;
    repeat (6) @(posedge clk_sys_in);
    #1 chk(cg[1], 16'h0200, "ext write moved gain");
    host.sel(3'h2);
    host.wr(ADDR_CAL_CMD, 16'h00A3);
    #1 chk(busy, 16'h0002, "busy on launch");
    for (int i = 1; i < 30; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (tg == 0 && cg[1] === 10'h155) begin
        tg = i;
        bg = busy[1];
      end
      if (to == 0 && co[1] === 10'h0AA) to = i;
    end
    chk(tg > 0 && to > tg, 1'b1, "gain before offset");
    chk(bg, 1'b1, "busy held between");
    chk(cp[1], 16'h0200, "phase not ordered");
    chk(cg[0], 16'h0200, "other bank untouched");
    chk(to, 16'h0004, "offset after gain ends");
    host.rd(ADDR_CAL_CMD, d);
    chk(d, 16'h00A0, "fields kept");
    host.wr(ADDR_CAL_BUSY, 16'h0001);
    host.rd(ADDR_CAL_BUSY, d);
    chk(d, 16'h0000, "busy read only");
    host.wr(ADDR_CAL_CMD, 16'h0008);
    repeat (8) @(posedge clk_sys_in);
    #1 chk(cp[1], 16'h03FF, "phase copied");
    @(posedge clk_sys_in);
    eg[1] <= 10'h001;
    eo[1] <= 10'h002;
    ep[1] <= 10'h003;
    foreach (v3[k]) host.wr(ADDR_CAL_CMD, v3[k]);
    repeat (8) @(posedge clk_sys_in);
    #1 chk(cg[1], 16'h0155, "idle codes");
    chk(co[1], 16'h00AA, "idle offset");
    chk(cp[1], 16'h03FF, "idle phase");
    $display("calibration test done");
  endtask : t_cal

  task automatic t_state;
    @(posedge clk_sys_in);
    act <= 4'h2;
    repeat (6) @(posedge clk_sys_in);
    host.sel(3'h2);
    host.rd(ADDR_CH_STATE, d);
    chk(d, 16'h0001, "active channel");
    host.sel(3'h1);
    host.rd(ADDR_CH_STATE, d);
    chk(d, 16'h0000, "standby channel");
    $display("state test done");
  endtask : t_state

  initial begin
    rstn_in <= 1'b0;
    act     <= 4'h0;
    eo      <= '0;
    eg      <= '0;
    ep      <= '0;
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    t_reset();
    t_trim();
    t_cal();
    t_state();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
